//--- hdl/fsb_pkg.sv
package fsb_pkg;
  localparam int OUT_N = 10;
  localparam int SYNC_W = 8;
  localparam int EN_STAGES = 2;
  localparam logic [1:0] SEL_A = 2'h0;
  localparam logic [1:0] SEL_B = 2'h1;
  localparam logic [SYNC_W-1:0] SYNC_RST = 8'h00;
  localparam logic [EN_STAGES-1:0] EN_RST = 2'h0;
  localparam logic SRC_RST = 1'h0;
  localparam int CLK_PERIOD_NS = 25;
  // Sync vector bit positions
  localparam int B_A_T = 0;
  localparam int B_A_C = 1;
  localparam int B_B_T = 2;
  localparam int B_B_C = 3;
  localparam int B_XT = 4;
  localparam int B_SEL0 = 5;
  localparam int B_SEL1 = 6;
  localparam int B_OE = 7;
endpackage : fsb_pkg

//--- hdl/fsb_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fsb_sync
  import fsb_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [SYNC_W-1:0] async_i,
  output logic [SYNC_W-1:0] sync_o
);
  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= SYNC_RST;
      sync_q <= SYNC_RST;
    end else if (ce_i) begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule : fsb_sync
`default_nettype wire

//--- hdl/fsb_fanout.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Select 00 pair A, 01 pair B, else crystal
// - Enable 0 tristates outputs, 1 drives them
// - Enable change applied on the second source rising edge after it is synchronised
// - Open selected pair drives outputs low
// - Pair A true high and comp low drives high, else low
// - Pair B true high and comp low drives high, else low
// - Unconnected select and enable default to zero
module fsb_fanout
  import fsb_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic diff_clock_a_true_i,
  input wire logic diff_clock_a_comp_i,
  input wire logic diff_clock_b_true_i,
  input wire logic diff_clock_b_comp_i,
  input wire logic crystal_osc_clock_i,
  input wire logic [1:0] src_sel_i,
  input wire logic out_en_i,
  output logic [OUT_N-1:0] clk_out_o,
  output logic [OUT_N-1:0] clk_out_oe_n_o
);
  logic [SYNC_W-1:0] pin_s;
  logic [1:0] sel_s;
  logic oe_s;
  logic dec_a;
  logic dec_b;
  logic src_d;
  logic src_q;
  logic src_rise;
  logic [EN_STAGES-1:0] en_q;

  fsb_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .async_i({out_en_i, src_sel_i, crystal_osc_clock_i,
              diff_clock_b_comp_i, diff_clock_b_true_i,
              diff_clock_a_comp_i, diff_clock_a_true_i}),
    .sync_o(pin_s)
  );

  // Pins reset to zero, as their pull-downs do
  assign sel_s = {pin_s[B_SEL1], pin_s[B_SEL0]};
  assign oe_s = pin_s[B_OE];
  // Equal lines (open pair) decode low
  assign dec_a = pin_s[B_A_T] & ~pin_s[B_A_C];
  assign dec_b = pin_s[B_B_T] & ~pin_s[B_B_C];

  always_comb begin
    unique case (sel_s)
      SEL_A: src_d = dec_a;
      SEL_B: src_d = dec_b;
      default: src_d = pin_s[B_XT];
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      src_q <= SRC_RST;
    end else if (ce_i) begin
      src_q <= src_d;
    end
  end

  assign src_rise = src_d & ~src_q;

  // Enable steps only on source rising edges, so it lands on the second
  // edge after the change and never cuts a pulse; no edges, no change
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_q <= EN_RST;
    end else if (ce_i && src_rise) begin
      en_q <= {en_q[0], oe_s};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < OUT_N; gi++) begin : g_out
      assign clk_out_o[gi] = src_q;
      assign clk_out_oe_n_o[gi] = ~en_q[EN_STAGES-1];
    end
  endgenerate

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  crystal_osc_clock_route_a: assert property (
    ce_i && sel_s[1] |=> src_q == $past(pin_s[B_XT]))
    else $error("crystal not routed");

  crystal_osc_clock_code10_a: assert property (
    ce_i && sel_s == 2'h2 |=> src_q == $past(pin_s[B_XT]))
    else $error("select 10 did not pick crystal");

  crystal_osc_clock_code11_a: assert property (
    ce_i && sel_s == 2'h3 |=> src_q == $past(pin_s[B_XT]))
    else $error("select 11 did not pick crystal");

  pair_a_route_a: assert property (
    ce_i && sel_s == SEL_A |=> src_q == $past(dec_a))
    else $error("pair A not routed");

  pair_b_route_a: assert property (
    ce_i && sel_s == SEL_B |=> src_q == $past(dec_b))
    else $error("pair B not routed");

  pair_a_high_a: assert property (
    ce_i && sel_s == SEL_A && pin_s[B_A_T] && !pin_s[B_A_C] |=> src_q)
    else $error("pair A high not passed");

  pair_a_low_a: assert property (
    ce_i && sel_s == SEL_A && !dec_a |=> !src_q)
    else $error("pair A low not passed");

  pair_b_high_a: assert property (
    ce_i && sel_s == SEL_B && dec_b |=> src_q)
    else $error("pair B high not passed");

  pair_b_low_a: assert property (
    ce_i && sel_s == SEL_B && !dec_b |=> !src_q)
    else $error("pair B low or open not passed");

  open_a_low_a: assert property (
    ce_i && sel_s == SEL_A && pin_s[B_A_T] == pin_s[B_A_C] |=> !src_q)
    else $error("open pair A not low");

  open_b_low_a: assert property (
    ce_i && sel_s == SEL_B && pin_s[B_B_T] == pin_s[B_B_C] |=> !src_q)
    else $error("open pair B not low");

  outputs_off_a: assert property (
    !en_q[1] |-> clk_out_oe_n_o == {OUT_N{1'b1}})
    else $error("outputs driven while disabled");

  outputs_on_a: assert property (
    en_q[1] |-> clk_out_oe_n_o == '0)
    else $error("outputs not driven while enabled");

  en_on_edge_a: assert property (
    $changed(en_q[1]) |-> $past(src_rise) && $past(ce_i) && src_q)
    else $error("enable changed off a source edge");

  en_two_stage_a: assert property (
    $changed(en_q[1]) |-> en_q[1] == $past(en_q[0]))
    else $error("enable skipped a stage");

  en_first_stage_a: assert property (
    ce_i && src_rise |=> en_q[0] == $past(oe_s))
    else $error("first enable stage missed the pin");

  en_stage_hold_a: assert property (
    ce_i && src_rise |=> en_q[1] == $past(en_q[0]))
    else $error("second enable stage missed");

  en_q0_hold_a: assert property (
    $changed(en_q[0]) |-> en_q[0] == $past(oe_s))
    else $error("first stage took a wrong value");

  en_rise_only_a: assert property (
    $changed(en_q[0]) |-> src_q)
    else $error("first stage moved off a rising edge");

  no_edge_hold_a: assert property (
    !(ce_i && src_rise) |=> $stable(en_q))
    else $error("enable moved without a source edge");

  out_data_reg_a: assert property (
    ce_i |=> clk_out_o == {OUT_N{$past(src_d)}})
    else $error("outputs missed the selected level");

  oe_sync_a: assert property (
    $past(nrst_i) && $past(nrst_i, 2) && $past(ce_i) && $past(ce_i, 2)
    |-> oe_s == $past(out_en_i, 2))
    else $error("enable pin not synchronised");

  sel_sync_a: assert property (
    $past(nrst_i) && $past(nrst_i, 2) && $past(ce_i) && $past(ce_i, 2)
    |-> sel_s == $past(src_sel_i, 2))
    else $error("select pins not synchronised");

  xt_sync_a: assert property (
    $past(nrst_i) && $past(nrst_i, 2) && $past(ce_i) && $past(ce_i, 2)
    |-> pin_s[B_XT] == $past(crystal_osc_clock_i, 2))
    else $error("crystal pin not synchronised");

  same_phase_a: assert property (
    clk_out_o == {OUT_N{clk_out_o[0]}} &&
    clk_out_oe_n_o == {OUT_N{clk_out_oe_n_o[0]}})
    else $error("outputs out of step");
endmodule : fsb_fanout
`default_nettype wire

//--- tb/fsb_board.sv
`timescale 1ns/1ps
`default_nettype none
module fsb_board (
  input wire logic sys_clk_i,
  input wire logic open_i,
  output logic [4:0] src_o
);
  logic [3:0] cnt_q = 4'h0;
  // Free-running source edges; open pairs fall to both lines low
  always @(negedge sys_clk_i) cnt_q <= cnt_q + 4'h1;
  assign src_o = {cnt_q[0], open_i ? 4'h0 :
    {~cnt_q[2], cnt_q[2], ~cnt_q[1], cnt_q[1]}};
endmodule : fsb_board
`default_nettype wire

//--- tb/fsb_fanout_test.sv
`timescale 1ns/1ps
`default_nettype none
module fsb_fanout_test;
  import fsb_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, oe = 1'b0, opn = 1'b0, oe_old = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [4:0] src;
  logic [OUT_N-1:0] q, oe_n;
  logic [3:0] h = 4'h0;
  int error_cnt = 0, compares = 0, rises = 9;
  fsb_board fsb_board_inst (.sys_clk_i(clk), .open_i(opn), .src_o(src));
  fsb_fanout fsb_fanout_inst (.sys_clk_i(clk), .nrst_i(nrst), .ce_i(1'b1),
    .diff_clock_a_true_i(src[0]), .diff_clock_a_comp_i(src[1]),
    .diff_clock_b_true_i(src[2]), .diff_clock_b_comp_i(src[3]),
    .crystal_osc_clock_i(src[4]), .src_sel_i(sel), .out_en_i(oe),
    .clk_out_o(q), .clk_out_oe_n_o(oe_n));
  initial forever #(CLK_PERIOD_NS / 2.0) clk = ~clk;
  task automatic check(input string nm, input logic [OUT_N-1:0] got, exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask : check
  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // Expected source level seen by the outputs
  function automatic logic pick(input logic [1:0] s, input logic [4:0] v);
    return s[1] ? v[4] : s[0] ? v[2] & ~v[3] : v[0] & ~v[1];
  endfunction : pick
  initial begin
    void'($urandom(32'h65C87137));
    repeat (2) @(negedge clk);
    check("oe_n reset", oe_n, {OUT_N{1'b1}});
    nrst = 1'b1;
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk);
      #1;
      if (i > 2) begin
        check("clk_out", q, {OUT_N{h[2]}});
        if (h[2] && !h[3]) rises++;
        if (rises < 2) check("oe_n hold", oe_n, {OUT_N{~oe_old}});
        if (rises > 3) check("oe_n", oe_n, {OUT_N{~oe}});
      end
      if ($urandom_range(7) == 0) sel = 2'($urandom);
      if ($urandom_range(15) == 0) opn = ~opn;
      // Next enable flip only once the previous one must have landed
      if (i > 2 && rises > 3 && $urandom_range(15) == 0) begin
        oe_old = oe;
        oe = ~oe;
        rises = 0;
      end
      h = {h[2:0], pick(sel, src)};
    end
    wrap_up();
  end
  initial begin
    #(CLK_PERIOD_NS * 4000);
    error_cnt++;
    wrap_up();
  end
endmodule : fsb_fanout_test
`default_nettype wire
